// ### logic/alcr_pkg.sv
// Purpose: Shared constants for the converter control and register block.
// Assumes: Byte-wide registers reached over a plain strobe port.
// Notes:   Offsets are word indices on the register port.
`default_nettype none
package alcr_pkg;

  // Register offsets on the 4-bit address port.
  localparam logic [3:0] OFF_CFG      = 4'h0;
  localparam logic [3:0] OFF_SC2      = 4'h1;
  localparam logic [3:0] OFF_SC1      = 4'h2;
  localparam logic [3:0] OFF_RES_HIGH = 4'h3;
  localparam logic [3:0] OFF_RES_LOW  = 4'h4;
  localparam logic [3:0] OFF_CMP_HIGH = 4'h5;
  localparam logic [3:0] OFF_CMP_LOW  = 4'h6;
  localparam logic [3:0] OFF_PIN_LOW  = 4'h7;
  localparam logic [3:0] OFF_PIN_HIGH = 4'h8;

  // Configuration register fields.
  localparam int CFG_LOW_POWER   = 7;
  localparam int CFG_DIV_HI      = 6;
  localparam int CFG_DIV_LO      = 5;
  localparam int CFG_LONG_SAMPLE = 4;
  localparam int CFG_RES_HI      = 3;
  localparam int CFG_RES_LO      = 2;
  localparam int CFG_CLK_HI      = 1;
  localparam int CFG_CLK_LO      = 0;

  // Second status/control register fields.
  localparam int SC2_ACTIVE  = 7;
  localparam int SC2_TRIGGER = 6;
  localparam int SC2_CMP_EN  = 5;
  localparam int SC2_CMP_GT  = 4;

  // First status/control register fields.
  localparam int SC1_COMPLETE = 7;
  localparam int SC1_IRQ_EN   = 6;
  localparam int SC1_CONT     = 5;

  // Field encodings.
  localparam logic [1:0] RES_TEN_BIT   = 2'h2;
  localparam logic [1:0] CLK_BUS       = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF  = 2'h1;
  localparam logic [1:0] CLK_ALT       = 2'h2;
  localparam logic [1:0] CLK_ASYNC     = 2'h3;
  localparam logic [4:0] CHAN_OFF      = 5'h1F;

  // Reset values.
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] SC2_RESET = 8'h00;
  localparam logic [7:0] SC1_RESET = 8'h1F;

  // Conversion lengths in internal conversion clock ticks.
  localparam logic [5:0] LEN_SHORT_8 = 6'h14;
  localparam logic [5:0] LEN_TEN_ADD = 6'h03;
  localparam logic [5:0] LEN_LONG_ADD = 6'h14;

endpackage : alcr_pkg
`default_nettype wire

// ### logic/alcr_top.sv
// Purpose: Control logic of a successive-approximation converter: registers,
//          clock selection, sequencing, compare, blocking and low power.
// Assumes: Analog code, stop requests and hardware trigger all come from
//          same-clock logic; the alternate clock arrives as an enable pulse.
// Notes:   Stop1/stop2 act like a reset on every register.
//
// How it works
// RL1 - Async clock keeps converter running in stop3.
// RL2 - Running conversion finishes during stop3 async.
// RL3 - Stop3 starts only hardware or continuous.
// RL4 - Completion sets flag, interrupt wakes stop3.
// RL5 - Stop1/stop2 return all registers to reset.
// RL6 - Configuration field layout, resolution 10 = 10-bit.
// RL7 - Divider 00 means divide by one.
// RL8 - Clock select 00 picks bus clock.
// RL9 - Second control bit 7 shows active.
// RL10 - Second control bit 6 selects trigger.
// RL11 - Bit 5 compare enable, bit 4 direction.
// RL12 - Second control bits 3:2 read zero.
// RL13 - Software writes zero to bits 1:0.
// RL14 - First control bit 7 complete flag.
// RL15 - First control bit 6 interrupt enable.
// RL16 - First control bit 5 continuous select.
// RL17 - First control bits 4:0 channel.
// RL18 - High byte read blocks result until low.
// RL19 - Compare value pair held for checking.
// RL20 - Pin control bits disable digital pins.
// RL21 - Software sets config, then controls.
// RL22 - First control write aborts and restarts.
// RL23 - Mode-change writes abort conversion.
// RL24 - Compare direction decides flag and transfer.
// RL25 - Stop3 without async clock aborts to idle.
// RL26 - Flag blocked wake-up in low power.
`timescale 1ns/10ps
`default_nettype none
module alcr_top #(
  parameter int ASYNC_DIV = 4,
  parameter int CODE_W    = 10
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic [3:0]        addr_i,
  input  wire logic [7:0]        wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rd_data_o,
  input  wire logic              stop3_i,
  input  wire logic              stop12_i,
  input  wire logic              hw_trigger_i,
  input  wire logic              alt_clk_en_i,
  input  wire logic [CODE_W-1:0] conv_code_i,
  output logic                   irq_o,
  output logic                   blocked_wake_o,
  output logic                   conv_active_o,
  output logic                   sample_o,
  output logic      [4:0]        channel_o,
  output logic                   low_power_o,
  output logic                   async_clk_on_o,
  output logic      [15:0]       pin_disable_o
);

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b01,
    ST_CONVERT = 2'b10
  } alcr_state_t;

  // Ticks needed for one conversion at the chosen sample and resolution.
  function automatic logic [5:0] conv_len(input logic long_s,
                                          input logic ten);
    return alcr_pkg::LEN_SHORT_8 +
           (ten ? alcr_pkg::LEN_TEN_ADD : 6'h00) +
           (long_s ? alcr_pkg::LEN_LONG_ADD : 6'h00);
  endfunction : conv_len

  ////////////////////////////////////////////////////////////////////////
  // Registers and decode.
  logic [7:0]        cfg_q;
  logic [7:0]        sc2_q;
  logic [7:0]        sc1_q;
  logic [CODE_W-1:0] cmp_q;
  logic [CODE_W-1:0] res_q;
  logic [7:0]        pin_low_q;
  logic [7:0]        pin_high_q;
  logic              complete_q;
  logic              lock_q;
  logic [7:0]        rd_data_q;
  alcr_state_t       state_q;
  logic [5:0]        tick_cnt_q;
  logic [2:0]        div_cnt_q;
  logic              half_q;
  logic [7:0]        async_cnt_q;
  logic              irq_q;
  logic              bwake_q;
  logic              wipe;
  logic              wr_cfg;
  logic              wr_sc2;
  logic              wr_sc1;
  logic              wr_cmp;
  logic              rd_high;
  logic              rd_low;
  logic              async_sel;
  logic              stop3_abort;
  logic              ten_bit;
  logic              src_tick;
  logic              internal_conv_clock_tick;
  logic              async_tick;
  logic              done;
  logic              start;
  logic [2:0]        div_mask;
  logic [CODE_W-1:0] code;
  logic [CODE_W-1:0] diff;
  logic              cmp_ok;
  logic              transfer;
  // RL5 stop1/2 reset
  assign wipe     = rst_i | stop12_i;
  assign wr_cfg   = wr_i && (addr_i == alcr_pkg::OFF_CFG);
  assign wr_sc2   = wr_i && (addr_i == alcr_pkg::OFF_SC2);
  assign wr_sc1   = wr_i && (addr_i == alcr_pkg::OFF_SC1);
  assign wr_cmp   = wr_i && ((addr_i == alcr_pkg::OFF_CMP_HIGH) ||
                             (addr_i == alcr_pkg::OFF_CMP_LOW));
  assign rd_high  = rd_i && (addr_i == alcr_pkg::OFF_RES_HIGH);
  assign rd_low   = rd_i && (addr_i == alcr_pkg::OFF_RES_LOW);
  // RL6 resolution decode
  assign ten_bit  = (cfg_q[alcr_pkg::CFG_RES_HI:alcr_pkg::CFG_RES_LO] ==
                     alcr_pkg::RES_TEN_BIT);
  assign async_sel = (cfg_q[alcr_pkg::CFG_CLK_HI:alcr_pkg::CFG_CLK_LO] ==
                      alcr_pkg::CLK_ASYNC);
  // RL25 stop3 abort
  assign stop3_abort = stop3_i && !async_sel;

  ////////////////////////////////////////////////////////////////////////
  // Configuration and control registers. Writes only store; the abort
  // and restart effects live in the sequencer below.
  always_ff @(posedge sys_clk_i) begin
    if (wipe) begin
      cfg_q      <= alcr_pkg::CFG_RESET;
      sc2_q      <= alcr_pkg::SC2_RESET;
      sc1_q      <= alcr_pkg::SC1_RESET;
      cmp_q      <= '0;
      pin_low_q  <= 8'h00;
      pin_high_q <= 8'h00;
    end else if (wr_i) begin
      case (addr_i)
        // RL6 configuration layout
        alcr_pkg::OFF_CFG: begin
          cfg_q <= wr_data_i;
        end
        // RL10 trigger and compare bits; RL12 bits 3:0 never stored.
        alcr_pkg::OFF_SC2: begin
          sc2_q <= {1'b0, wr_data_i[6:4], 4'h0};
        end
        // RL17 channel and modes
        alcr_pkg::OFF_SC1: begin
          sc1_q <= {1'b0, wr_data_i[6:0]};
        end
        // RL19 compare value pair
        alcr_pkg::OFF_CMP_HIGH: begin
          cmp_q[CODE_W-1:8] <= wr_data_i[CODE_W-9:0];
        end
        alcr_pkg::OFF_CMP_LOW: begin
          cmp_q[7:0] <= wr_data_i;
        end
        // RL20 pin control
        alcr_pkg::OFF_PIN_LOW: begin
          pin_low_q <= wr_data_i;
        end
        alcr_pkg::OFF_PIN_HIGH: begin
          pin_high_q <= wr_data_i;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock source selection and divider, all as enables of sys_clk_i.
  // The async oscillator only runs while selected, to save power.
  always_ff @(posedge sys_clk_i) begin
    if (wipe || !async_sel || async_tick) begin
      async_cnt_q <= 8'h00;
    end else begin
      async_cnt_q <= async_cnt_q + 8'h01;
    end
  end
  assign async_tick = async_sel && (async_cnt_q == 8'(ASYNC_DIV - 1));
  // Bus clock divided by two, as a strobe on every other cycle.
  always_ff @(posedge sys_clk_i) begin
    half_q <= wipe ? 1'b0 : ~half_q;
  end
  // RL8 source select
  always_comb begin
    case (cfg_q[alcr_pkg::CFG_CLK_HI:alcr_pkg::CFG_CLK_LO])
      alcr_pkg::CLK_BUS:      src_tick = 1'b1;
      alcr_pkg::CLK_BUS_HALF: src_tick = half_q;
      alcr_pkg::CLK_ALT:      src_tick = alt_clk_en_i;
      default:                src_tick = async_tick;
    endcase
  end

  // RL7 divide by 1,2,4,8
  always_comb begin
    case (cfg_q[alcr_pkg::CFG_DIV_HI:alcr_pkg::CFG_DIV_LO])
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (wipe) begin
      div_cnt_q <= 3'h0;
    end else if (src_tick) begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end
  assign internal_conv_clock_tick = src_tick && ((div_cnt_q & div_mask) == div_mask);

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.
  // RL3 stop3 start sources
  assign start = (sc1_q[4:0] != alcr_pkg::CHAN_OFF) && !stop3_abort &&
                 sc2_q[alcr_pkg::SC2_TRIGGER] && hw_trigger_i;
  assign done  = (state_q == ST_CONVERT) && internal_conv_clock_tick &&
                 (tick_cnt_q == conv_len(cfg_q[alcr_pkg::CFG_LONG_SAMPLE],
                                         ten_bit) - 6'h01);

  // RL1 keep running
  // RL2 finish in stop3
  always_ff @(posedge sys_clk_i) begin
    if (wipe) begin
      state_q    <= ST_IDLE;
      tick_cnt_q <= 6'h00;
    // RL25 abort to idle
    end else if (stop3_abort || wr_cfg || wr_sc2 || wr_cmp) begin
      // RL23 mode change abort
      state_q    <= ST_IDLE;
      tick_cnt_q <= 6'h00;
    end else if (wr_sc1) begin
      // RL22 abort and restart
      tick_cnt_q <= 6'h00;
      // RL3 stop3 blocks software start
      state_q    <= ((wr_data_i[4:0] != alcr_pkg::CHAN_OFF) && !stop3_i &&
                     !sc2_q[alcr_pkg::SC2_TRIGGER]) ? ST_CONVERT : ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q    <= ST_CONVERT;
            tick_cnt_q <= 6'h00;
          end
        end
        ST_CONVERT: begin
          if (done) begin
            tick_cnt_q <= 6'h00;
            // RL16 continuous select
            if (!sc1_q[alcr_pkg::SC1_CONT]) begin
              state_q <= ST_IDLE;
            end
          end else if (internal_conv_clock_tick) begin
            tick_cnt_q <= tick_cnt_q + 6'h01;
          end
        end
        default: begin
          state_q    <= ST_IDLE;
          tick_cnt_q <= 6'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare and result transfer. In 8-bit mode the code is scaled down.
  assign code = ten_bit ? conv_code_i :
                {{(CODE_W-8){1'b0}}, conv_code_i[CODE_W-1:CODE_W-8]};
  assign diff = code + ~cmp_q + {{(CODE_W-1){1'b0}}, 1'b1};
  // RL24 compare direction
  // RL11 compare enable
  assign cmp_ok = !sc2_q[alcr_pkg::SC2_CMP_EN] ||
                  (sc2_q[alcr_pkg::SC2_CMP_GT] ? (code >= cmp_q)
                                               : (code < cmp_q));
  // RL18 blocked transfer
  assign transfer = done && cmp_ok && !lock_q;

  // Results survive aborts; only reset and stop1/2 clear them.
  always_ff @(posedge sys_clk_i) begin
    if (wipe) begin
      res_q <= '0;
    end else if (transfer) begin
      res_q <= sc2_q[alcr_pkg::SC2_CMP_EN] ? diff : code;
    end
  end

  // RL18 high-then-low lock
  always_ff @(posedge sys_clk_i) begin
    if (wipe) begin
      lock_q <= 1'b0;
    end else if (rd_high) begin
      lock_q <= 1'b1;
    end else if (rd_low) begin
      lock_q <= 1'b0;
    end
  end

  // RL14 completion flag
  // RL4 flag on completion; a new completion wins over a clear.
  always_ff @(posedge sys_clk_i) begin
    if (wipe) begin
      complete_q <= 1'b0;
    end else if (transfer) begin
      complete_q <= 1'b1;
    end else if (wr_sc1 || rd_low) begin
      complete_q <= 1'b0;
    end
  end

  // RL15 interrupt enable
  // RL4 interrupt wakes stop3
  always_ff @(posedge sys_clk_i) begin
    if (wipe) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (complete_q || transfer) && sc1_q[alcr_pkg::SC1_IRQ_EN] &&
               !wr_sc1 && !(rd_low && !transfer);
    end
  end

  // RL26 blocked wake pulse
  // A completion discarded by the lock in stop3 would wake the system with
  // no interrupt, so it is reported separately for one cycle.
  always_ff @(posedge sys_clk_i) begin
    if (wipe) begin
      bwake_q <= 1'b0;
    end else begin
      bwake_q <= done && cmp_ok && lock_q && stop3_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: data stand in the cycle after the strobe only.
  always_ff @(posedge sys_clk_i) begin
    if (wipe || !rd_i) begin
      rd_data_q <= 8'h00;
    end else begin
      case (addr_i)
        alcr_pkg::OFF_CFG:      rd_data_q <= cfg_q;
        // RL9 active flag
        alcr_pkg::OFF_SC2:      rd_data_q <= {state_q == ST_CONVERT,
                                              sc2_q[6:0]};
        alcr_pkg::OFF_SC1:      rd_data_q <= {complete_q, sc1_q[6:0]};
        alcr_pkg::OFF_RES_HIGH: rd_data_q <= 8'(res_q[CODE_W-1:8]);
        alcr_pkg::OFF_RES_LOW:  rd_data_q <= res_q[7:0];
        alcr_pkg::OFF_CMP_HIGH: rd_data_q <= 8'(cmp_q[CODE_W-1:8]);
        alcr_pkg::OFF_CMP_LOW:  rd_data_q <= cmp_q[7:0];
        alcr_pkg::OFF_PIN_LOW:  rd_data_q <= pin_low_q;
        alcr_pkg::OFF_PIN_HIGH: rd_data_q <= pin_high_q;
        default:                rd_data_q <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered status toward the analog core and the system.
  logic       active_q;
  logic       sample_q;
  logic [4:0] chan_q;
  logic       lp_q;
  logic       async_on_q;

  always_ff @(posedge sys_clk_i) begin
    if (wipe) begin
      active_q   <= 1'b0;
      sample_q   <= 1'b0;
      chan_q     <= alcr_pkg::CHAN_OFF;
      lp_q       <= 1'b0;
      async_on_q <= 1'b0;
    end else begin
      active_q   <= (state_q == ST_CONVERT);
      sample_q   <= done;
      chan_q     <= sc1_q[4:0];
      lp_q       <= cfg_q[alcr_pkg::CFG_LOW_POWER];
      async_on_q <= async_sel && (state_q == ST_CONVERT);
    end
  end

  assign rd_data_o      = rd_data_q;
  assign irq_o          = irq_q;
  assign blocked_wake_o = bwake_q;
  assign conv_active_o  = active_q;
  assign sample_o       = sample_q;
  assign channel_o      = chan_q;
  assign low_power_o    = lp_q;
  assign async_clk_on_o = async_on_q;
  assign pin_disable_o  = {pin_high_q, pin_low_q};

endmodule : alcr_top
`default_nettype wire

// ### dv/alcr_properties.sv
// Purpose: Port-level properties of the converter control block.
// Assumes: One clock; rst_i and stop12_i both return registers to reset.
// Notes:   Trigger and clock selections are shadowed from bus writes.
`timescale 1ns/10ps
`default_nettype none
module alcr_properties (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  addr_i,
  input wire logic [7:0]  wr_data_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rd_data_o,
  input wire logic        stop3_i,
  input wire logic        stop12_i,
  input wire logic        hw_trigger_i,
  input wire logic        irq_o,
  input wire logic        blocked_wake_o,
  input wire logic        conv_active_o,
  input wire logic [4:0]  channel_o,
  input wire logic        low_power_o,
  input wire logic [15:0] pin_disable_o
);
  logic       hw_mode_q;
  logic [1:0] clk_sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Shadow of selections that never reach a port; the start and stop3 abort rules need them.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || stop12_i) begin
      hw_mode_q <= 1'b0;
      clk_sel_q <= 2'h0;
    end else if (wr_i && addr_i == alcr_pkg::OFF_SC2) begin
      hw_mode_q <= wr_data_i[alcr_pkg::SC2_TRIGGER];
    end else if (wr_i && addr_i == alcr_pkg::OFF_CFG) begin
      clk_sel_q <= wr_data_i[1:0];
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i || stop12_i);

  sequence s_sc1_wr;
    wr_i && addr_i == alcr_pkg::OFF_SC1 && !hw_trigger_i;
  endsequence
  sequence s_mode_wr;
    wr_i && !hw_trigger_i && (addr_i == alcr_pkg::OFF_CFG ||
      addr_i == alcr_pkg::OFF_SC2 || addr_i == alcr_pkg::OFF_CMP_HIGH ||
      addr_i == alcr_pkg::OFF_CMP_LOW);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_sc2_low_zero: assert property ($past(rd_i) &&
    $past(addr_i) == alcr_pkg::OFF_SC2 |-> rd_data_o[3:0] == 4'h0)
    else $error("trigger control low bits read nonzero");
  a_sc1_chan_read: assert property ($past(rd_i) &&
    $past(addr_i) == alcr_pkg::OFF_SC1 |-> rd_data_o[4:0] == channel_o)
    else $error("channel read differs from channel output");
  a_chan_write: assert property (s_sc1_wr |-> ##2
    channel_o == $past(wr_data_i[4:0], 2))
    else $error("channel not taken from write");
  a_sc1_starts: assert property (s_sc1_wr ##0 (!hw_mode_q && !stop3_i &&
    wr_data_i[4:0] != alcr_pkg::CHAN_OFF) |-> ##2 conv_active_o)
    else $error("software start did not begin a conversion");
  a_chan_off_idle: assert property (s_sc1_wr ##0
    (wr_data_i[4:0] == alcr_pkg::CHAN_OFF) |-> ##2 !conv_active_o)
    else $error("channel off write left converter active");
  a_mode_abort: assert property (s_mode_wr |-> ##2 !conv_active_o)
    else $error("mode change did not abort conversion");
  a_stop3_idle: assert property ((stop3_i &&
    clk_sel_q != alcr_pkg::CLK_ASYNC)[*3] |-> !conv_active_o)
    else $error("converter active in stop3 without async clock");
  a_stop12_reset: assert property (disable iff (rst_i) stop12_i |=>
    channel_o == alcr_pkg::CHAN_OFF && !irq_o && !low_power_o &&
    pin_disable_o == 16'h0000 && !conv_active_o)
    else $error("deep stop did not restore reset state");
  a_pin_write: assert property (wr_i &&
    addr_i == alcr_pkg::OFF_PIN_LOW |=> pin_disable_o[7:0] == $past(wr_data_i))
    else $error("pin control low byte not stored");
  a_cfg_low_power: assert property (wr_i &&
    addr_i == alcr_pkg::OFF_CFG |-> ##2
    low_power_o == $past(wr_data_i[7], 2))
    else $error("low power select not stored");
  a_blocked_wake: assert property (blocked_wake_o |->
    $past(stop3_i) || $past(stop3_i, 2))
    else $error("blocked wake pulse outside stop3");
endmodule : alcr_properties

bind alcr_top alcr_properties i_alcr_properties (.sys_clk_i, .rst_i, .addr_i,
  .wr_data_i, .wr_i, .rd_i, .rd_data_o, .stop3_i, .stop12_i, .hw_trigger_i,
  .irq_o, .blocked_wake_o, .conv_active_o, .channel_o, .low_power_o,
  .pin_disable_o);
`default_nettype wire

// ### dv/test_adc_lowpower_and_config_regs.sv
// Purpose: Directed bench for the converter control block.
// Assumes: Analog code and triggers come from here; alternate clock off.
// Notes:   Each task drives one scenario and judges it before returning.
`timescale 1ns/10ps
`default_nettype none
module test_adc_lowpower_and_config_regs;
  logic        sys_clk_i, rst_i, wr_i, rd_i, stop3_i, stop12_i;
  logic        hw_trigger_i, irq_o, blocked_wake_o, conv_active_o;
  logic        low_power_o, async_clk_on_o, sample_o;
  logic [3:0]  addr_i;
  logic [7:0]  wr_data_i, rd_data_o, d;
  logic [9:0]  conv_code_i;
  logic [4:0]  channel_o;
  logic [15:0] pin_disable_o;
  int          mismatches, n_tests, i;

  // The alternate clock enable stays low: that source is not exercised.
  alcr_top i_alcr_top (.sys_clk_i, .rst_i, .addr_i, .wr_data_i, .wr_i,
    .rd_i, .rd_data_o, .stop3_i, .stop12_i, .hw_trigger_i,
    .alt_clk_en_i(1'b0), .conv_code_i, .irq_o, .blocked_wake_o,
    .conv_active_o, .sample_o, .channel_o, .low_power_o, .async_clk_on_o,
    .pin_disable_o);

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("Counts: %0d checks, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Ends one step past the edge so outputs have settled.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    addr_i    <= a;
    wr_data_i <= v;
    wr_i      <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask : rd

  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(d, e);
  endtask : rc

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc

  // Polls the completion flag; a lapse of the bound ends the run.
  task automatic wflag;
    for (int k = 0; k < 300; k++) begin
      rd(alcr_pkg::OFF_SC1);
      if (d[7] === 1'b1) return;
    end
    mismatches++;
    results();
  endtask : wflag

  ////////////////////////////////////////////////////////////////////////////
  // reset and unmapped reads.
  task automatic t_reset;
    rc(alcr_pkg::OFF_CFG, 8'h00);
    rc(alcr_pkg::OFF_SC2, 8'h00);
    rc(alcr_pkg::OFF_SC1, 8'h1F);
    wr(alcr_pkg::OFF_SC2, 8'h0C);
    rc(alcr_pkg::OFF_SC2, 8'h00);
    wr(4'hF, 8'hFF);
    rc(4'hF, 8'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_single;
    conv_code_i <= 10'h2A5;
    wr(alcr_pkg::OFF_CFG, 8'h98);
    wr(alcr_pkg::OFF_SC2, 8'h00);
    wr(alcr_pkg::OFF_SC1, 8'h41);
    rd(alcr_pkg::OFF_SC2);
    chk(d[7], 1'b1);
    chk(low_power_o, 1'b1);
    chk(channel_o, 5'h01);
    wflag();
    cyc(2);
    chk(irq_o, 1'b1);
    rc(alcr_pkg::OFF_RES_HIGH, 8'h02);
    rc(alcr_pkg::OFF_RES_LOW, 8'hA5);
    cyc(2);
    chk(irq_o, 1'b0);
    $display("t_single done");
  endtask : t_single

  // high read locks out the next result.
  task automatic t_lock;
    wr(alcr_pkg::OFF_CFG, 8'h00);
    wr(alcr_pkg::OFF_SC1, 8'h01);
    wflag();
    rc(alcr_pkg::OFF_RES_HIGH, 8'h00);
    conv_code_i <= 10'h155;
    wr(alcr_pkg::OFF_SC1, 8'h01);
    cyc(60);
    chk(conv_active_o, 1'b0);
    rd(alcr_pkg::OFF_SC1);
    chk(d[7], 1'b0);
    rc(alcr_pkg::OFF_RES_LOW, 8'hA9);
    $display("t_lock done");
  endtask : t_lock

  task automatic t_compare;
    wr(alcr_pkg::OFF_CFG, 8'h08);
    wr(alcr_pkg::OFF_CMP_HIGH, 8'h01);
    wr(alcr_pkg::OFF_CMP_LOW, 8'h00);
    wr(alcr_pkg::OFF_SC2, 8'h30);
    conv_code_i <= 10'h100;
    wr(alcr_pkg::OFF_SC1, 8'h00);
    wflag();
    rc(alcr_pkg::OFF_RES_HIGH, 8'h00);
    rc(alcr_pkg::OFF_RES_LOW, 8'h00);
    conv_code_i <= 10'h0FF;
    wr(alcr_pkg::OFF_SC1, 8'h00);
    cyc(60);
    rd(alcr_pkg::OFF_SC1);
    chk(d[7], 1'b0);
    wr(alcr_pkg::OFF_SC2, 8'h20);
    wr(alcr_pkg::OFF_SC1, 8'h00);
    wflag();
    rc(alcr_pkg::OFF_RES_LOW, 8'hFF);
    $display("t_compare done");
  endtask : t_compare

  task automatic pulse_trigger;
    @(posedge sys_clk_i);
    hw_trigger_i <= 1'b1;
    @(posedge sys_clk_i);
    hw_trigger_i <= 1'b0;
  endtask : pulse_trigger

  // hardware trigger and async clock in stop3.
  task automatic t_stop3_async;
    wr(alcr_pkg::OFF_CFG, 8'h00);
    wr(alcr_pkg::OFF_SC2, 8'h40);
    wr(alcr_pkg::OFF_SC1, 8'h01);
    cyc(5);
    chk(conv_active_o, 1'b0);
    pulse_trigger();
    wflag();
    wr(alcr_pkg::OFF_CFG, 8'h03);
    wr(alcr_pkg::OFF_SC2, 8'h00);
    stop3_i <= 1'b1;
    wr(alcr_pkg::OFF_SC1, 8'h01);
    cyc(5);
    chk(conv_active_o, 1'b0);
    wr(alcr_pkg::OFF_SC2, 8'h40);
    pulse_trigger();
    cyc(6);
    chk(async_clk_on_o, 1'b1);
    wflag();
    stop3_i <= 1'b0;
    wr(alcr_pkg::OFF_SC2, 8'h00);
    wr(alcr_pkg::OFF_SC1, 8'h01);
    stop3_i <= 1'b1;
    cyc(4);
    chk(conv_active_o, 1'b1);
    wflag();
    stop3_i <= 1'b0;
    $display("t_stop3_async done");
  endtask : t_stop3_async

  // stop3 on the bus clock aborts, result kept.
  task automatic t_stop3_abort;
    wr(alcr_pkg::OFF_CFG, 8'h00);
    conv_code_i <= 10'h3FC;
    wr(alcr_pkg::OFF_SC1, 8'h01);
    wflag();
    conv_code_i <= 10'h000;
    wr(alcr_pkg::OFF_SC1, 8'h01);
    stop3_i <= 1'b1;
    cyc(40);
    chk(conv_active_o, 1'b0);
    rd(alcr_pkg::OFF_SC1);
    chk(d[7], 1'b0);
    rc(alcr_pkg::OFF_RES_LOW, 8'hFF);
    stop3_i <= 1'b0;
    $display("t_stop3_abort done");
  endtask : t_stop3_abort

  // discarded completion during stop3 is signalled.
  task automatic t_wake;
    wr(alcr_pkg::OFF_CFG, 8'h03);
    wr(alcr_pkg::OFF_SC1, 8'h21);
    rd(alcr_pkg::OFF_RES_HIGH);
    stop3_i <= 1'b1;
    for (i = 0; i < 300 && blocked_wake_o !== 1'b1; i++) cyc(1);
    chk(blocked_wake_o, 1'b1);
    chk(sample_o, 1'b1);
    chk(conv_active_o, 1'b1);
    if (i == 300) results();
    stop3_i <= 1'b0;
    rd(alcr_pkg::OFF_RES_LOW);
    $display("t_wake done");
  endtask : t_wake

  // pin control, then deep stop clears everything.
  task automatic t_pins_stop12;
    wr(alcr_pkg::OFF_PIN_LOW, 8'h02);
    wr(alcr_pkg::OFF_PIN_HIGH, 8'h81);
    chk(pin_disable_o, 16'h8102);
    wr(alcr_pkg::OFF_CFG, 8'h98);
    wr(alcr_pkg::OFF_SC1, 8'h41);
    wr(alcr_pkg::OFF_SC1, 8'h5F);
    cyc(1);
    chk(conv_active_o, 1'b0);
    wr(alcr_pkg::OFF_SC1, 8'h41);
    @(posedge sys_clk_i);
    stop12_i <= 1'b1;
    @(posedge sys_clk_i);
    stop12_i <= 1'b0;
    rc(alcr_pkg::OFF_CFG, 8'h00);
    rc(alcr_pkg::OFF_SC1, 8'h1F);
    chk(pin_disable_o, 16'h0000);
    $display("t_pins_stop12 done");
  endtask : t_pins_stop12

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    {wr_i, rd_i, stop3_i, stop12_i, hw_trigger_i} = 5'h00;
    addr_i = 4'h0;
    wr_data_i = 8'h00;
    conv_code_i = 10'h000;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_single();
    t_lock();
    t_compare();
    t_stop3_async();
    t_stop3_abort();
    t_wake();
    t_pins_stop12();
    results();
  end
endmodule : test_adc_lowpower_and_config_regs
`default_nettype wire
